// ==== rtl/ilcd_pkg.sv ====
// package for the inband loopback code detector: register map, fields, timing
// assumes one clock domain at 125 MHz and 32-bit AHB-Lite register access
package ilcd_pkg;
    // ****************************************
    // register word indexes and byte addresses
    // ****************************************
    localparam logic [7:0] ILCD_IDX_CFG = 8'h3c;
    localparam logic [7:0] ILCD_IDX_IES = 8'h3d;
    localparam logic [7:0] ILCD_IDX_ACT = 8'h3e;
    localparam logic [7:0] ILCD_IDX_DEACT = 8'h3f;
    localparam logic [7:0] ILCD_IDX_STAT = 8'h40;
    localparam logic [7:0] ILCD_IDX_CLR = 8'h41;
    localparam logic [7:0] ILCD_IDX_IEN = 8'h42;
    localparam logic [11:0] ILCD_ADDR_CFG = {2'h0, ILCD_IDX_CFG, 2'h0};
    localparam logic [11:0] ILCD_ADDR_IES = {2'h0, ILCD_IDX_IES, 2'h0};
    localparam logic [11:0] ILCD_ADDR_ACT = {2'h0, ILCD_IDX_ACT, 2'h0};
    localparam logic [11:0] ILCD_ADDR_DEACT = {2'h0, ILCD_IDX_DEACT, 2'h0};
    localparam logic [11:0] ILCD_ADDR_STAT = {2'h0, ILCD_IDX_STAT, 2'h0};
    localparam logic [11:0] ILCD_ADDR_CLR = {2'h0, ILCD_IDX_CLR, 2'h0};
    localparam logic [11:0] ILCD_ADDR_IEN = {2'h0, ILCD_IDX_IEN, 2'h0};
    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int ILCD_CFG_SPEEDUP = 7;
    localparam int ILCD_IES_ACT_PRES = 7;
    localparam int ILCD_IES_DEACT_PRES = 6;
    localparam int ILCD_IES_ACT_IE = 5;
    localparam int ILCD_IES_DEACT_IE = 4;
    localparam int ILCD_IES_ACT_CHG = 3;
    localparam int ILCD_IES_DEACT_CHG = 2;
    localparam int ILCD_IES_ACT_DET = 1;
    localparam int ILCD_IES_DEACT_DET = 0;
    localparam logic [7:0] ILCD_RST_BYTE = 8'h00;
    // ****************************************
    // timing
    // ****************************************
    localparam real ILCD_CLK_MHZ = 125.0;
    localparam real ILCD_WINDOW_MS = 39.8;
    localparam int ILCD_WINDOW_CYC = int'(ILCD_WINDOW_MS * ILCD_CLK_MHZ * 1000.0 - 0.5);
    localparam int ILCD_SPEEDUP_DIV = 256;
    typedef struct packed {
        logic [1:0] deact_sel;
        logic [1:0] act_sel;
        logic test_speedup;
        logic act_ie;
        logic deact_ie;
    } ilcd_ctrl_s;
endpackage

// ==== rtl/ilcd_detector.sv ====
// inband loopback code detector with AHB-Lite register slave
// assumes rx_bit/rx_bit_valid synchronous to hclk, one valid per line bit
`timescale 1ns/1ps
`default_nettype none
// Contract
// - two-bit length selector: 00 five, 01 six, 10 seven, 11 eight bits
// - presence flag set when the pattern was seen during the 39.8 ms interval
// - activate enable gates every activate detect change onto processor_irq_n; irq uses the enable register instead
// - deactivate enable gates every deactivate detect change onto processor_irq_n; irq uses the enable register instead
// - per-pattern change flag shows that a detect change raised the interrupt
// - read-only current detect state for each pattern
// - activate pattern register, msb is first received bit
// - deactivate pattern register, msb is earliest received bit
// - reset clears patterns, selectors, test bit and enables
module ilcd_detector #(
    parameter int WINDOW_CYC = ilcd_pkg::ILCD_WINDOW_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic rx_bit,
    input wire logic rx_bit_valid,
    output logic processor_irq_n,
    output logic irq
);
    // ****************************************
    // bus slave
    // ****************************************
    function automatic logic [3:0] pat_len(input logic [1:0] sel);
        unique case (sel)
            2'h0: pat_len = 4'h5;
            2'h1: pat_len = 4'h6;
            2'h2: pat_len = 4'h7;
            2'h3: pat_len = 4'h8;
        endcase
    endfunction

    function automatic logic pat_match(input logic [7:0] hist, input logic [7:0] pat, input logic [1:0] sel);
        logic ok;
        int n;
        ok = 1'b1;
        n = int'(pat_len(sel));
        for (int i = 0; i < 8; i++) begin
            if (i < n) begin
                if (hist[n - 1 - i] != pat[7 - i]) begin
                    ok = 1'b0;
                end
            end
        end
        pat_match = ok;
    endfunction

    logic ap_valid_q;
    logic ap_valid_d;
    logic ap_write_q;
    logic ap_write_d;
    logic [11:0] ap_addr_q;
    logic [11:0] ap_addr_d;
    ilcd_pkg::ilcd_ctrl_s ctrl_q;
    ilcd_pkg::ilcd_ctrl_s ctrl_d;
    logic [7:0] act_pat_q;
    logic [7:0] act_pat_d;
    logic [7:0] deact_pat_q;
    logic [7:0] deact_pat_d;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic [1:0] sticky_q;
    logic [1:0] sticky_d;
    logic [1:0] ien_q;
    logic [1:0] ien_d;
    logic irq_q;
    logic irq_d;
    logic irq_n_q;
    logic irq_n_d;
    logic ies_read;
    logic wr_act;
    logic wr_clr;

    always_comb begin
        ap_valid_d = hsel & hready & htrans[1];
        ap_write_d = hwrite;
        ap_addr_d = haddr[11:0];
        ctrl_d = ctrl_q;
        act_pat_d = act_pat_q;
        deact_pat_d = deact_pat_q;
        ien_d = ien_q;
        wr_act = ap_valid_q & ap_write_q;
        wr_clr = 1'b0;
        if (wr_act) begin
            unique case (ap_addr_q)
                ilcd_pkg::ILCD_ADDR_CFG: begin
                    ctrl_d.test_speedup = hwdata[ilcd_pkg::ILCD_CFG_SPEEDUP];
                    ctrl_d.deact_sel = hwdata[3:2];
                    ctrl_d.act_sel = hwdata[1:0];
                end
                ilcd_pkg::ILCD_ADDR_IES: begin
                    ctrl_d.act_ie = hwdata[ilcd_pkg::ILCD_IES_ACT_IE];
                    ctrl_d.deact_ie = hwdata[ilcd_pkg::ILCD_IES_DEACT_IE];
                end
                ilcd_pkg::ILCD_ADDR_ACT: act_pat_d = hwdata[7:0];
                ilcd_pkg::ILCD_ADDR_DEACT: deact_pat_d = hwdata[7:0];
                ilcd_pkg::ILCD_ADDR_CLR: wr_clr = 1'b1;
                ilcd_pkg::ILCD_ADDR_IEN: ien_d = hwdata[1:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // bus and control registers
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_addr_q <= 12'h000;
            ctrl_q <= '0;
            act_pat_q <= ilcd_pkg::ILCD_RST_BYTE;
            deact_pat_q <= ilcd_pkg::ILCD_RST_BYTE;
            ien_q <= 2'h0;
        end else begin
            ap_valid_q <= ap_valid_d;
            ap_write_q <= ap_write_d;
            ap_addr_q <= ap_addr_d;
            ctrl_q <= ctrl_d;
            act_pat_q <= act_pat_d;
            deact_pat_q <= deact_pat_d;
            ien_q <= ien_d;
        end
    end

    // ****************************************
    // pattern detection
    // ****************************************
    logic [7:0] hist_q;
    logic [7:0] hist_d;
    logic [31:0] win_q;
    logic [31:0] win_d;
    logic [1:0] seen_q;
    logic [1:0] seen_d;
    logic [1:0] miss_q;
    logic [1:0] miss_d;
    logic [1:0] det_q;
    logic [1:0] det_d;
    logic [1:0] pres_q;
    logic [1:0] pres_d;
    logic [1:0] chg_q;
    logic [1:0] chg_d;
    logic [1:0] match;
    logic [31:0] win_len;
    logic win_end;

    // ****************************************
    // observation window counter
    // ****************************************
    always_comb begin
        win_len = ctrl_q.test_speedup ? 32'(WINDOW_CYC / ilcd_pkg::ILCD_SPEEDUP_DIV) : 32'(WINDOW_CYC);
        if (win_len == 32'h0) begin
            win_len = 32'h1;
        end
        win_end = (win_q >= win_len - 32'h1);
        win_d = win_end ? 32'h0 : win_q + 32'h1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            win_q <= 32'h0;
        end else begin
            win_q <= win_d;
        end
    end

    always_comb begin
        hist_d = hist_q;
        seen_d = seen_q;
        miss_d = miss_q;
        det_d = det_q;
        pres_d = pres_q;
        match[1] = pat_match(hist_q, act_pat_q, ctrl_q.act_sel);
        match[0] = pat_match(hist_q, deact_pat_q, ctrl_q.deact_sel);
        if (rx_bit_valid) begin
            hist_d = {hist_q[6:0], rx_bit};
            seen_d = seen_q | match;
            miss_d = miss_q | ~match;
        end
        if (win_end) begin
            pres_d = seen_d;
            for (int i = 0; i < 2; i++) begin
                if (!miss_d[i]) begin
                    det_d[i] = 1'b1;
                end else if (!seen_d[i]) begin
                    det_d[i] = 1'b0;
                end
            end
            seen_d = 2'h0;
            miss_d = 2'h0;
        end
    end

    // ****************************************
    // detection registers
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hist_q <= 8'h00;
            seen_q <= 2'h0;
            miss_q <= 2'h0;
            det_q <= 2'h0;
            pres_q <= 2'h0;
        end else begin
            hist_q <= hist_d;
            seen_q <= seen_d;
            miss_q <= miss_d;
            det_q <= det_d;
            pres_q <= pres_d;
        end
    end

    // ****************************************
    // change flags, status and interrupts
    // ****************************************
    logic [1:0] edge_ev;
    logic [7:0] ies_byte;

    always_comb begin
        edge_ev = det_d ^ det_q;
        ies_read = ap_valid_q & ~ap_write_q & (ap_addr_q == ilcd_pkg::ILCD_ADDR_IES);
        chg_d = chg_q;
        if (ies_read) begin
            chg_d = 2'h0;
        end
        chg_d[1] = chg_d[1] | (edge_ev[1] & ctrl_q.act_ie);
        chg_d[0] = chg_d[0] | (edge_ev[0] & ctrl_q.deact_ie);
        sticky_d = sticky_q;
        if (wr_clr) begin
            sticky_d = sticky_q & ~hwdata[1:0];
        end
        sticky_d = sticky_d | edge_ev;
        irq_d = |(sticky_d & ien_q);
        irq_n_d = ~|chg_d;
        ies_byte = {pres_q, ctrl_q.act_ie, ctrl_q.deact_ie, chg_q, det_q};
        hrdata_d = 32'h0;
        if (hsel & hready & htrans[1] & ~hwrite) begin
            unique case (haddr[11:0])
                ilcd_pkg::ILCD_ADDR_CFG: hrdata_d = {24'h0, ctrl_q.test_speedup, 3'h0, ctrl_q.deact_sel, ctrl_q.act_sel};
                ilcd_pkg::ILCD_ADDR_IES: hrdata_d = {24'h0, ies_byte};
                ilcd_pkg::ILCD_ADDR_ACT: hrdata_d = {24'h0, act_pat_q};
                ilcd_pkg::ILCD_ADDR_DEACT: hrdata_d = {24'h0, deact_pat_q};
                ilcd_pkg::ILCD_ADDR_STAT: hrdata_d = {30'h0, sticky_q};
                ilcd_pkg::ILCD_ADDR_IEN: hrdata_d = {30'h0, ien_q};
                default: hrdata_d = 32'h0;
            endcase
        end
    end

    // ****************************************
    // status registers
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chg_q <= 2'h0;
            sticky_q <= 2'h0;
        end else begin
            chg_q <= chg_d;
            sticky_q <= sticky_d;
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
            irq_n_q <= 1'b1;
            hrdata_q <= 32'h0;
        end else begin
            irq_q <= irq_d;
            irq_n_q <= irq_n_d;
            hrdata_q <= hrdata_d;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign processor_irq_n = irq_n_q;
    assign irq = irq_q;
endmodule
`default_nettype wire

// ==== tb/ilcd_detector_asserts.sv ====
// checker for the loopback code detector bus and interrupt outputs
// assumes a bind to ilcd_detector, one hclk domain
`timescale 1ns/1ps
`default_nettype none
module ilcd_detector_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic processor_irq_n,
    input wire logic irq
);
    // ****
    // bus and interrupt properties
    // ****
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic tk, wr, ies;
    assign tk = hsel && hready && htrans[1];
    assign wr = tk && hwrite;
    assign ies = tk && !hwrite && haddr[11:0] == 12'h0f4;
    sequence s_rd(a);
        tk && !hwrite && haddr[11:0] == a ##1 1'b1;
    endsequence
    AST_READY: assert property (hreadyout) else $error("hreadyout low");
    AST_OKAY: assert property (!hresp) else $error("hresp not okay");
    AST_RDATA_IDLE: assert property (hrdata != 32'h0 |-> $past(tk) && !$past(hwrite)) else $error("stray hrdata");
    AST_UNMAPPED: assert property (s_rd(12'h0a0) |-> hrdata == 32'h0) else $error("unmapped read nonzero");
    AST_CFG_RSVD: assert property (s_rd(12'h0f0) |-> hrdata[31:8] == 24'h0 && hrdata[6:4] == 3'h0)
        else $error("cfg unused bits set");
    AST_RST_OUT: assert property ($rose(hresetn) |-> processor_irq_n && !irq)
        else $error("irq active after reset");
    AST_IRQN_HOLD: assert property (!processor_irq_n && !ies && !$past(ies) && !$past(ies, 2) && !$past(ies, 3)
        |=> !processor_irq_n) else $error("irq_n released without read");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr, 2) || $past(wr, 3) || $past(wr, 4))
        else $error("irq fell without write");
endmodule
bind ilcd_detector ilcd_detector_asserts u_ilcd_detector_asserts (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hrdata, .hreadyout, .hresp, .processor_irq_n, .irq);
`default_nettype wire

// ==== tb/ilcd_line_model.sv ====
// line model: repeats the eight code bits, first bit from the msb
// assumes hclk domain; one bit is offered every gap+1 cycles
`timescale 1ns/1ps
`default_nettype none
module ilcd_line_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] code,
    input wire logic [3:0] gap,
    output logic rx_bit,
    output logic rx_bit_valid
);
    // ****
    // bit pacing
    // ****
    logic [3:0] tick_q;
    logic [2:0] pos_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_q <= 4'h0;
            pos_q <= 3'h0;
        end else begin
            tick_q <= (tick_q >= gap) ? 4'h0 : tick_q + 4'h1;
            pos_q <= pos_q + {2'h0, rx_bit_valid};
        end
    end
    assign rx_bit_valid = (tick_q == gap);
    // inverse of the bit outside its valid cycle
    assign rx_bit = code[~pos_q] ^ ~rx_bit_valid;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the loopback code detector
// assumes the line model as far side and a short window
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ****
    // bench
    // ****
    localparam int WIN = 200;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, d;
    logic hreadyout, hresp, rx_bit, rx_bit_valid, processor_irq_n, irq;
    logic [7:0] line_code = 8'hff;
    logic [7:0] e8;
    logic [3:0] gap = 4'h3;
    logic [31:0] lfsr = 32'h9c2a;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    ilcd_detector #(.WINDOW_CYC(WIN)) u_ilcd_detector (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_bit, .rx_bit_valid,
        .processor_irq_n, .irq);
    ilcd_line_model u_ilcd_line_model (.hclk, .hresetn, .code(line_code), .gap, .rx_bit, .rx_bit_valid);
    initial forever #4 hclk = ~hclk;
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // an all-ones line matches when the first n code bits are ones
    function automatic logic det(input logic [7:0] c, input int n);
        return (c >> (8 - n)) == (8'hff >> (8 - n));
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, d & m);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rd("cfg", ilcd_pkg::ILCD_ADDR_CFG, 32'hffffffff, 32'h0);
        rd("ies", ilcd_pkg::ILCD_ADDR_IES, 32'h30, 32'h0);
        rd("act", ilcd_pkg::ILCD_ADDR_ACT, 32'hffffffff, 32'h0);
        rd("deact", ilcd_pkg::ILCD_ADDR_DEACT, 32'hffffffff, 32'h0);
        bus(1'b1, 12'h0a0, 32'hff);
        rd("unmapped", 12'h0a0, 32'hffffffff, 32'h0);
        for (int i = 0; i < 3; i++) begin
            lfsr = nxt(lfsr);
            bus(1'b1, ilcd_pkg::ILCD_ADDR_ACT, lfsr);
            bus(1'b1, ilcd_pkg::ILCD_ADDR_DEACT, ~lfsr);
            bus(1'b1, ilcd_pkg::ILCD_ADDR_CFG, lfsr & 32'h0f);
            rd("act rw", ilcd_pkg::ILCD_ADDR_ACT, 32'hffffffff, lfsr & 32'hff);
            rd("deact rw", ilcd_pkg::ILCD_ADDR_DEACT, 32'hffffffff, ~lfsr & 32'hff);
            rd("cfg rw", ilcd_pkg::ILCD_ADDR_CFG, 32'hffffffff, lfsr & 32'h0f);
        end
        bus(1'b1, ilcd_pkg::ILCD_ADDR_ACT, 32'hfc);
        bus(1'b1, ilcd_pkg::ILCD_ADDR_DEACT, 32'hfe);
        for (int s = 0; s < 4; s++) begin
            lfsr = nxt(lfsr);
            gap <= {1'b0, lfsr[2:0]};
            bus(1'b1, ilcd_pkg::ILCD_ADDR_CFG, 32'(5 * s));
            repeat (3 * WIN) @(posedge hclk);
            e8 = {det(8'hfc, 5 + s), det(8'hfe, 5 + s), 4'h0, det(8'hfc, 5 + s), det(8'hfe, 5 + s)};
            rd("detect", ilcd_pkg::ILCD_ADDR_IES, 32'hc3, {24'h0, e8});
        end
        bus(1'b1, ilcd_pkg::ILCD_ADDR_CFG, 32'h05);
        repeat (3 * WIN) @(posedge hclk);
        bus(1'b1, ilcd_pkg::ILCD_ADDR_IES, 32'h30);
        bus(1'b1, ilcd_pkg::ILCD_ADDR_IEN, 32'h03);
        bus(1'b1, ilcd_pkg::ILCD_ADDR_CLR, 32'h03);
        rd("ies idle", ilcd_pkg::ILCD_ADDR_IES, 32'hff, 32'hf3);
        chk("irq idle", 32'h0, irq);
        line_code <= 8'h00;
        repeat (3 * WIN) @(posedge hclk);
        chk("irq_n set", 32'h0, processor_irq_n);
        chk("irq set", 32'h1, irq);
        rd("flags", ilcd_pkg::ILCD_ADDR_IES, 32'hff, 32'h3c);
        repeat (3) @(posedge hclk);
        chk("irq_n clear", 32'h1, processor_irq_n);
        rd("flags clear", ilcd_pkg::ILCD_ADDR_IES, 32'h0c, 32'h0);
        rd("stat", ilcd_pkg::ILCD_ADDR_STAT, 32'hffffffff, 32'h3);
        bus(1'b1, ilcd_pkg::ILCD_ADDR_CLR, 32'h1);
        bus(1'b1, ilcd_pkg::ILCD_ADDR_IEN, 32'h1);
        rd("stat part", ilcd_pkg::ILCD_ADDR_STAT, 32'hffffffff, 32'h2);
        chk("irq masked", 32'h0, irq);
        rd("clr reads 0", ilcd_pkg::ILCD_ADDR_CLR, 32'hffffffff, 32'h0);
        bus(1'b1, ilcd_pkg::ILCD_ADDR_IES, 32'h0);
        line_code <= 8'hff;
        repeat (3 * WIN) @(posedge hclk);
        chk("irq_n off", 32'h1, processor_irq_n);
        rd("no flags", ilcd_pkg::ILCD_ADDR_IES, 32'hff, 32'hc3);
        chk("irq on", 32'h1, irq);
        bus(1'b1, ilcd_pkg::ILCD_ADDR_CLR, 32'h3);
        rd("stat clear", ilcd_pkg::ILCD_ADDR_STAT, 32'hffffffff, 32'h0);
        chk("irq off", 32'h0, irq);
        final_report();
    end
endmodule
`default_nettype wire
